// file: core/ddc_channel.sv
// Contract
// - Q test enable bit 2 replaces Q samples with inverted generator A output per the 4-bit test select, else normal Q.
// - I test enable bit 0 replaces I samples with generator A output per the test select, else normal I.
// - Control bit 7 picks real mixer (both from one channel) at 0 or complex mixer (separate I and Q) at 1.
// - Control bit 6 selects unity gain at 0 or times-two gain at 1.
// - Control bits 5:4 select variable, zero, quarter-rate or test IF mode.
// - Control bit 3 at 1 makes only a real I output via an extra quarter-rate mix; at 0 both I and Q are valid.
// - Decimation 000/001/010 gives 4/8/16 complex, halved for real output.
// - Decimation 011 gives 2 complex or 1 real; 100 gives 6 complex or 3 real.
// - Both registers reset to zero.
`timescale 1ns/1ns
module ddc_channel #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// register port
	input wire logic [15:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// shared test select
	input wire logic [3:0] testSelect,
	// converter samples
	input wire logic [WIDTH-1:0] chanA,
	input wire logic [WIDTH-1:0] chanB,
	input wire logic sampleValid,
	input wire logic [WIDTH-1:0] ncoCos,
	input wire logic [WIDTH-1:0] ncoSin,
	// output stream
	output logic [WIDTH-1:0] outI,
	output logic [WIDTH-1:0] outQ,
	output logic outQValid,
	output logic outValid,
	input wire logic outReady
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0] testEnable_reg;
		logic [7:0] control_reg;
		logic [7:0] rdData;
		logic [1:0] phase;
		logic [WIDTH-1:0] pattern;
		logic [WIDTH-1:0] oI;
		logic [WIDTH-1:0] oQ;
		logic oQv;
		logic oV;
	} ddc_chan_state_type;
	ddc_chan_state_type state_reg, state_next;

	logic mixerComplex, gain2, c2r, testI, testQ, keep, fifoInReady, fifoOutValid;
	logic [1:0] ifMode;
	logic [2:0] decSel;
	logic [WIDTH-1:0] srcI, srcQ, mixI, mixQ, gI, gQ, rI, rQ, selI, selQ;
	logic [2*WIDTH-1:0] fifoIn, fifoOut;
	logic [2*WIDTH-1:0] prodI, prodQ;

	assign testI = state_reg.testEnable_reg[ddc_pkg::TEST_I_BIT];
	assign testQ = state_reg.testEnable_reg[ddc_pkg::TEST_Q_BIT];
	assign mixerComplex = state_reg.control_reg[ddc_pkg::MIXER_BIT];
	assign gain2 = state_reg.control_reg[ddc_pkg::GAIN_BIT];
	assign ifMode = state_reg.control_reg[ddc_pkg::IF_MSB:ddc_pkg::IF_LSB];
	assign c2r = state_reg.control_reg[ddc_pkg::C2R_BIT];
	assign decSel = state_reg.control_reg[ddc_pkg::DEC_MSB:ddc_pkg::DEC_LSB];

	// ****************************************
	// datapath
	// ****************************************
	// real mixer takes both from channel A
	assign srcI = chanA;
	assign srcQ = mixerComplex ? chanB : chanA;

	assign prodI = $signed(srcI) * $signed(ncoCos);
	assign prodQ = $signed(srcQ) * $signed(ncoSin);

	// IF mode mixing
	always_comb begin
		case (ifMode)
			ddc_pkg::IF_VARIABLE: begin
				mixI = prodI[2*WIDTH-2 -: WIDTH];
				mixQ = prodQ[2*WIDTH-2 -: WIDTH];
			end
			ddc_pkg::IF_ZERO: begin
				mixI = srcI;
				mixQ = srcQ;
			end
			ddc_pkg::IF_QUARTER: begin
				case (state_reg.phase)
					2'h0: begin mixI = srcI; mixQ = '0; end
					2'h1: begin mixI = '0; mixQ = -srcQ; end
					2'h2: begin mixI = -srcI; mixQ = '0; end
					default: begin mixI = '0; mixQ = srcQ; end
				endcase
			end
			default: begin
				mixI = ncoCos;
				mixQ = ncoSin;
			end
		endcase
	end

	// gain stage
	assign gI = gain2 ? {mixI[WIDTH-2:0], 1'b0} : mixI;
	assign gQ = gain2 ? {mixQ[WIDTH-2:0], 1'b0} : mixQ;

	// complex to real with extra quarter-rate mix
	always_comb begin
		rI = gI;
		rQ = gQ;
		if (c2r) begin
			rQ = '0;
			case (state_reg.phase)
				2'h0: rI = gI;
				2'h1: rI = -gQ;
				2'h2: rI = -gI;
				default: rI = gQ;
			endcase
		end
	end

	// test pattern substitution
	assign selI = testI ? state_reg.pattern : rI;
	assign selQ = testQ ? ~state_reg.pattern : rQ;

	ddc_decimator u_dec (
		.clk(clk),
		.rst(rst),
		.clkEn(clkEn),
		.decSel(decSel),
		.realOut(c2r),
		.inStrobe(sampleValid && fifoInReady),
		.keep(keep),
		.ratio()
	);

	assign fifoIn = {selI, selQ};

	ddc_fifo #(
		.WIDTH(2*WIDTH),
		.DEPTH(ddc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.clkEn(clkEn),
		.inData(fifoIn),
		.inValid(keep),
		.inReady(fifoInReady),
		.outData(fifoOut),
		.outValid(fifoOutValid),
		.outReady(outReady)
	);

	// ****************************************
	// registers and output stage
	// ****************************************
	always_comb begin
		state_next = state_reg;
		if (regWrite && regAddr == ddc_pkg::TEST_ENABLE_ADDR)
			state_next.testEnable_reg = regWrData & ddc_pkg::TEST_ENABLE_MASK;
		if (regWrite && regAddr == ddc_pkg::CONTROL_ADDR)
			state_next.control_reg = regWrData & ddc_pkg::CONTROL_MASK;
		if (regRead) begin
			case (regAddr)
				ddc_pkg::TEST_ENABLE_ADDR: state_next.rdData = state_reg.testEnable_reg;
				ddc_pkg::CONTROL_ADDR: state_next.rdData = state_reg.control_reg;
				default: state_next.rdData = 8'h00;
			endcase
		end
		if (sampleValid && fifoInReady) begin
			state_next.phase = state_reg.phase + 2'h1;
			// pattern generator: ramp, alternating, or fixed per select
			case (testSelect)
				4'h0: state_next.pattern = '0;
				4'h1: state_next.pattern = {1'b0, {(WIDTH-1){1'b1}}};
				4'h2: state_next.pattern = {1'b1, {(WIDTH-1){1'b0}}};
				4'h3: state_next.pattern = ~state_reg.pattern;
				default: state_next.pattern = state_reg.pattern + 1'b1;
			endcase
		end
		if (outReady) begin
			state_next.oV = fifoOutValid;
			// empty buffer slot holds no sample; keep the last one
			if (fifoOutValid) begin
				state_next.oI = fifoOut[2*WIDTH-1:WIDTH];
				state_next.oQ = fifoOut[WIDTH-1:0];
			end
			state_next.oQv = fifoOutValid && !c2r;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.testEnable_reg <= ddc_pkg::TEST_ENABLE_RESET;
			state_reg.control_reg <= ddc_pkg::CONTROL_RESET;
		end else if (clkEn) begin
			state_reg <= state_next;
		end
	end

	assign regRdData = state_reg.rdData;
	assign outI = state_reg.oI;
	assign outQ = state_reg.oQ;
	assign outQValid = state_reg.oQv;
	assign outValid = state_reg.oV;
endmodule : ddc_channel

// file: core/ddc_decimator.sv
`timescale 1ns/1ns
module ddc_decimator (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// selection
	input wire logic [2:0] decSel,
	input wire logic realOut,
	// strobe
	input wire logic inStrobe,
	output logic keep,
	output logic [5:0] ratio
);
	typedef struct packed {
		logic [5:0] count;
	} ddc_dec_state_type;
	ddc_dec_state_type state_reg, state_next;
	logic [5:0] full;

	// total ratio; real output halves it
	always_comb begin
		case (decSel)
			ddc_pkg::DEC_HB12: full = ddc_pkg::RATIO_HB12;
			ddc_pkg::DEC_HB123: full = ddc_pkg::RATIO_HB123;
			ddc_pkg::DEC_HB1234: full = ddc_pkg::RATIO_HB1234;
			ddc_pkg::DEC_HALF1: full = ddc_pkg::RATIO_HALF1;
			ddc_pkg::DEC_HALF1_THIRD: full = ddc_pkg::RATIO_HALF1_THIRD;
			default: full = ddc_pkg::RATIO_HB12;
		endcase
		ratio = realOut ? {1'b0, full[5:1]} : full;
	end

	assign keep = inStrobe && (state_reg.count == 6'h00);

	always_comb begin
		state_next = state_reg;
		if (inStrobe) begin
			if (state_reg.count + 6'h01 >= ratio) state_next.count = 6'h00;
			else state_next.count = state_reg.count + 6'h01;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) state_reg <= '0;
		else if (clkEn) state_reg <= state_next;
	end
endmodule : ddc_decimator

// file: core/ddc_fifo.sv
`timescale 1ns/1ns
module ddc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = ddc_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// write side
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	// read side
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wrPtr;
		logic [AW:0] rdPtr;
	} ddc_fifo_state_type;
	ddc_fifo_state_type state_reg, state_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full, empty, doWr, doRd;

	assign empty = state_reg.wrPtr == state_reg.rdPtr;
	assign full = (state_reg.wrPtr[AW] != state_reg.rdPtr[AW]) &&
		(state_reg.wrPtr[AW-1:0] == state_reg.rdPtr[AW-1:0]);
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[state_reg.rdPtr[AW-1:0]];
	assign doWr = clkEn && inValid && !full;
	assign doRd = clkEn && outReady && !empty;

	always_comb begin
		state_next = state_reg;
		if (doWr) state_next.wrPtr = state_reg.wrPtr + 1'b1;
		if (doRd) state_next.rdPtr = state_reg.rdPtr + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (doWr) mem[state_reg.wrPtr[AW-1:0]] <= inData;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) state_reg <= '0;
		else state_reg <= state_next;
	end
endmodule : ddc_fifo

// file: shared/ddc_pkg.sv
package ddc_pkg;
	// register map
	localparam logic [15:0] TEST_ENABLE_ADDR = 16'h0367;
	localparam logic [15:0] CONTROL_ADDR = 16'h0370;
	localparam logic [7:0] TEST_ENABLE_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] TEST_ENABLE_MASK = 8'h05;
	localparam logic [7:0] CONTROL_MASK = 8'hFF;
	// field positions
	localparam int TEST_I_BIT = 0;
	localparam int TEST_Q_BIT = 2;
	localparam int MIXER_BIT = 7;
	localparam int GAIN_BIT = 6;
	localparam int IF_MSB = 5;
	localparam int IF_LSB = 4;
	localparam int C2R_BIT = 3;
	localparam int DEC_MSB = 2;
	localparam int DEC_LSB = 0;
	localparam int TEST_SEL_MSB = 3;
	// IF modes
	typedef enum logic [1:0] {
		IF_VARIABLE = 2'h0,
		IF_ZERO = 2'h1,
		IF_QUARTER = 2'h2,
		IF_TEST = 2'h3
	} ddc_if_mode_type;
	// decimation selections
	typedef enum logic [2:0] {
		DEC_HB12 = 3'h0,
		DEC_HB123 = 3'h1,
		DEC_HB1234 = 3'h2,
		DEC_HALF1 = 3'h3,
		DEC_HALF1_THIRD = 3'h4
	} ddc_dec_type;
	localparam logic [5:0] RATIO_HB12 = 6'h04;
	localparam logic [5:0] RATIO_HB123 = 6'h08;
	localparam logic [5:0] RATIO_HB1234 = 6'h10;
	localparam logic [5:0] RATIO_HALF1 = 6'h02;
	localparam logic [5:0] RATIO_HALF1_THIRD = 6'h06;
	localparam int FIFO_DEPTH = 32;
endpackage : ddc_pkg

// file: tb/ddc_channel_props.sv
`timescale 1ns/1ns
module ddc_channel_props #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// register port
	input wire logic [15:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	input wire logic [3:0] testSelect,
	// output stream
	input wire logic [WIDTH-1:0] outI,
	input wire logic [WIDTH-1:0] outQ,
	input wire logic outQValid,
	input wire logic outValid,
	input wire logic outReady
);
	// ********************
	// register shadows
	// ********************
	logic [7:0] ctl_reg;
	logic [7:0] te_reg;
	logic rd;
	assign rd = clkEn && regRead;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctl_reg <= 8'h00;
			te_reg <= 8'h00;
		end else if (clkEn && regWrite) begin
			if (regAddr == ddc_pkg::CONTROL_ADDR) ctl_reg <= regWrData;
			if (regAddr == ddc_pkg::TEST_ENABLE_ADDR) te_reg <= regWrData & 8'h05;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_CTL_READBACK: assert property (rd && regAddr == ddc_pkg::CONTROL_ADDR |=>
		regRdData == $past(ctl_reg)) else $error("control readback differs");
	AST_TE_READBACK: assert property (rd && regAddr == ddc_pkg::TEST_ENABLE_ADDR |=>
		regRdData == $past(te_reg)) else $error("test enable readback differs");
	AST_UNMAPPED: assert property (rd && regAddr != ddc_pkg::CONTROL_ADDR
		&& regAddr != ddc_pkg::TEST_ENABLE_ADDR |=> regRdData == 8'h00) else $error("unmapped read not zero");
	AST_RD_STANDS: assert property (!rd |=> $stable(regRdData)) else $error("read data moved");
	AST_OUT_HOLD: assert property (clkEn && !outReady |=>
		$stable(outI) && $stable(outQ) && $stable(outValid)) else $error("output moved while stalled");
	AST_C2R_NO_Q: assert property (ctl_reg[3] && $past(ctl_reg[3], 4) |-> !outQValid)
		else $error("q valid in real output");
	AST_TEST_I: assert property (outValid && te_reg[0] && $past(te_reg[0], 6) && testSelect == 4'h0
		&& $past(testSelect, 6) == 4'h0 |-> outI == '0) else $error("i test pattern wrong");
	AST_TEST_Q: assert property (outValid && te_reg[2] && $past(te_reg[2], 6) && testSelect == 4'h0
		&& $past(testSelect, 6) == 4'h0 |-> outQ == '1) else $error("q test pattern wrong");
endmodule : ddc_channel_props
bind ddc_channel ddc_channel_props #(.WIDTH(WIDTH)) chk_u (.*);

// file: tb/test_ddc_channel.sv
`timescale 1ns/1ns
module test_ddc_channel;
	// ********************
	// stimulus and checks
	// ********************
	logic clk = 1'h0;
	logic rst, clkEn, regWrite, regRead, sampleValid, outReady, outQValid, outValid;
	logic [15:0] regAddr, chanA, chanB, ncoCos, ncoSin, outI, outQ;
	logic [7:0] regWrData, regRdData;
	logic [3:0] testSelect;
	int miscompares = 0;
	int num_checks = 0;
	int nOut, nQ;
	ddc_channel dut_u (.*);
	always #5 clk = ~clk;
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] exp, input logic [15:0] got, input string nm);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrite = 1'h1;
		tick;
		regWrite = 1'h0;
		tick;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		regAddr = a;
		regRead = 1'h1;
		tick;
		regRead = 1'h0;
		chk(16'(e), 16'(regRdData), "regRdData");
		tick;
	endtask : rd
	// samples for n cycles, then drains; counts transfers
	task automatic run(input int n);
		nOut = 0;
		nQ = 0;
		for (int k = 0; k < n + 40; k++) begin
			sampleValid = k < n;
			tick;
			if (outValid === 1'h1 && outReady) nOut++;
			if (outValid === 1'h1 && outQValid === 1'h1) nQ++;
		end
	endtask : run
	task automatic rst_dut;
		rst = 1'h1;
		repeat (2) tick;
		rst = 1'h0;
	endtask : rst_dut
	task automatic t_regs;
		rst_dut;
		rd(ddc_pkg::TEST_ENABLE_ADDR, 8'h00);
		rd(ddc_pkg::CONTROL_ADDR, 8'h00);
		wr(ddc_pkg::TEST_ENABLE_ADDR, 8'hFF);
		rd(ddc_pkg::TEST_ENABLE_ADDR, 8'h05);
		wr(ddc_pkg::CONTROL_ADDR, 8'hA5);
		wr(16'h0368, 8'hFF);
		rd(16'h0368, 8'h00);
		rd(ddc_pkg::CONTROL_ADDR, 8'hA5);
	endtask : t_regs
	task automatic t_mix;
		logic [7:0] cv[5] = '{8'h93, 8'h13, 8'hD3, 8'hB3, 8'h83};
		logic [31:0] ev[5] = '{32'h01230456, 32'h01230123, 32'h024608AC, 32'h03210654, 32'h00070036};
		rst_dut;
		for (int i = 0; i < 5; i++) begin
			wr(ddc_pkg::CONTROL_ADDR, cv[i]);
			run(8);
			chk(ev[i][31:16], outI, "outI");
			chk(ev[i][15:0], outQ, "outQ");
		end
	endtask : t_mix
	task automatic t_test;
		logic [15:0] pat[3] = '{16'h0000, 16'h7FFF, 16'h8000};
		rst_dut;
		wr(ddc_pkg::CONTROL_ADDR, 8'h93);
		wr(ddc_pkg::TEST_ENABLE_ADDR, 8'h05);
		for (int s = 0; s < 3; s++) begin
			testSelect = 4'(s);
			run(8);
			chk(pat[s], outI, "outI");
			chk(~pat[s], outQ, "outQ");
		end
		wr(ddc_pkg::TEST_ENABLE_ADDR, 8'h00);
		run(8);
		chk(16'h0123, outI, "outI");
		chk(16'h0456, outQ, "outQ");
	endtask : t_test
	task automatic t_dec;
		int rat[5] = '{4, 8, 16, 2, 6};
		for (int d = 0; d < 5; d++) begin
			for (int c = 0; c < 2; c++) begin
				rst_dut;
				wr(ddc_pkg::CONTROL_ADDR, 8'h10 | 8'(c << 3) | 8'(d));
				run(48);
				chk(16'(48 / (rat[d] >> c)), 16'(nOut), "outCount");
				chk(16'(c ? 0 : 48 / rat[d]), 16'(nQ), "qCount");
			end
		end
		rst_dut;
		wr(ddc_pkg::CONTROL_ADDR, 8'h17);
		run(48);
		chk(16'(48 / 4), 16'(nOut), "outCount");
		// frozen clock enable ignores a write
		rst_dut;
		clkEn = 1'h0;
		wr(ddc_pkg::CONTROL_ADDR, 8'h55);
		clkEn = 1'h1;
		rd(ddc_pkg::CONTROL_ADDR, 8'h00);
	endtask : t_dec
	// stall until the buffer refuses, then drain
	task automatic t_fill;
		rst_dut;
		wr(ddc_pkg::CONTROL_ADDR, 8'h1B);
		outReady = 1'h0;
		run(40);
		outReady = 1'h1;
		run(0);
		chk(16'(ddc_pkg::FIFO_DEPTH), 16'(nOut), "drained");
	endtask : t_fill
	task automatic end_sim;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	initial begin
		rst = 1'h1;
		clkEn = 1'h1;
		regWrite = 1'h0;
		regRead = 1'h0;
		sampleValid = 1'h0;
		outReady = 1'h1;
		regAddr = 16'h0000;
		regWrData = 8'h00;
		testSelect = 4'h0;
		chanA = 16'h0123;
		chanB = 16'h0456;
		ncoCos = 16'h0321;
		ncoSin = 16'h0654;
		t_regs;
		t_mix;
		t_test;
		t_dec;
		t_fill;
		end_sim;
	end
	initial begin
		#100000;
		miscompares++;
		end_sim;
	end
endmodule : test_ddc_channel
